//--- spicfg_consts.svh
// Constants for the SPI configuration and status register block
`ifndef SPICFG_CONSTS_SVH
`define SPICFG_CONSTS_SVH
`define SPICFG_ADDR 8'ha1
`define SPICFG_BIT_BUSY 7
`define SPICFG_BIT_MSTR 6
`define SPICFG_BIT_CPHA 5
`define SPICFG_BIT_CPOL 4
`define SPICFG_BIT_SEL 3
`define SPICFG_BIT_RAW 2
`define SPICFG_BIT_SHIFTER_EMPTY_FLAG 1
`define SPICFG_BIT_RXMT 0
`define SPICFG_WR_MASK 8'h70
`define SPICFG_RESET 8'h07
`define SPICFG_MODE_3WIRE 2'h0
`define SPICFG_MODE_4WIRE 2'h1
`define SPICFG_GLITCH_NS 20
`define SPICFG_GLITCH_CYC ((`SPICFG_GLITCH_NS + 9) / 10)
`endif

//--- spicfg_pkg.sv
// Types for the SPI configuration and status register block
package spicfg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spicfg_bus_s;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_HOLD
    } spicfg_state_e;
endpackage

//--- spicfg_top.sv
// SPI configuration/status register with link-side shifter and flags
//
// How it works
// [R1] Busy bit high while transfer runs
// [R2] Bit 6 picks slave or master
// [R3] Bit 5 picks first or second edge
// [R4] Bit 4 sets serial clock idle level
// [R5] Selected flag reads one when select low
// [R6] Selected flag comes from filtered select
// [R7] Bit 2 returns raw select pin level
// [R8] Shifter empty set when nothing pending
// [R9] Shifter empty cleared on load or edge
// [R10] Shifter empty reads one as master
// [R11] Rx empty set after buffer read
// [R12] Rx empty cleared on new byte
// [R13] Rx empty reads one as master
// [R14] Slave samples data at bit centre
// [R15] Master samples late in each bit
// [R16] Select mode 00, 01, 1x meanings
// [R17] Enable bit gates the port
// [R18] Status bits are read-only
`timescale 1ns/1ps
`include "spicfg_consts.svh"
module spicfg_top
    import spicfg_pkg::*;
#(
    parameter int GLITCH_CYC = `SPICFG_GLITCH_CYC
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access
    input wire spicfg_bus_s bus,
    output logic [7:0] rdata,
    // Port control from the control register
    input wire logic port_enable,
    input wire logic [1:0] select_pin_mode,
    // Master engine status and data path
    input wire logic master_busy,
    input wire logic tx_load,
    input wire logic rx_read,
    // Link side, clocked by the serial clock
    input wire logic sck_link,
    input wire logic slave_select_n,
    input wire logic mosi,
    // Received byte
    output logic [7:0] rx_byte
);
    // ------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------
    logic master_select_q;
    logic clock_phase_select_q;
    logic clock_polarity_select_q;
    logic reg_hit;
    assign reg_hit = bus.addr == `SPICFG_ADDR;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            master_select_q <= 1'b0;
            clock_phase_select_q <= 1'b0;
            clock_polarity_select_q <= 1'b0;
        end else if (clk_en && bus.wr && reg_hit) begin
            // Only bits 6..4 store; status bits ignore writes
            master_select_q <= bus.wdata[`SPICFG_BIT_MSTR]; // [R2] [R18]
            clock_phase_select_q <= bus.wdata[`SPICFG_BIT_CPHA]; // [R3]
            clock_polarity_select_q <= bus.wdata[`SPICFG_BIT_CPOL]; // [R4]
        end
    end

    // ------------------------------------------------------------
    // Select pin: raw sync and de-glitch filter
    // ------------------------------------------------------------
    logic ss_m_q;
    logic ss_s_q;
    logic [7:0] glitch_cnt_q;
    logic ss_filt_q;
    logic use_ss;
    // Mode 00 has no pin; 1x drives it out, so only 01 listens
    assign use_ss = select_pin_mode == `SPICFG_MODE_4WIRE; // [R16]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ss_m_q <= 1'b1;
            ss_s_q <= 1'b1;
        end else if (clk_en) begin
            ss_m_q <= slave_select_n;
            ss_s_q <= ss_m_q; // [R7]
        end
    end
    // Level must hold GLITCH_CYC cycles before the flag follows
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            glitch_cnt_q <= 8'h00;
            ss_filt_q <= 1'b1;
        end else if (clk_en) begin
            if (ss_s_q == ss_filt_q) begin
                glitch_cnt_q <= 8'h00;
            end else if (glitch_cnt_q >= 8'(GLITCH_CYC - 1)) begin
                ss_filt_q <= ss_s_q; // [R6]
                glitch_cnt_q <= 8'h00;
            end else begin
                glitch_cnt_q <= glitch_cnt_q + 8'h01;
            end
        end
    end
    logic selected_flag;
    assign selected_flag = !ss_filt_q; // [R5]

    // ------------------------------------------------------------
    // Slave shifter on the link clock
    // ------------------------------------------------------------
    // Link clock may stop; counter cleared by select deassert in mode 01, or by port disable
    logic slave_active;
    logic link_rst_n;
    assign slave_active = port_enable && !master_select_q; // [R17]
    assign link_rst_n = rst_n && slave_active &&
        !(use_ss && slave_select_n);
    logic sample_clk;
    // Sampling edge sits mid-bit: leading edge for phase 0
    assign sample_clk = sck_link ^ clock_polarity_select_q ^
        clock_phase_select_q; // [R3] [R4] [R14]
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic byte_tgl_q;
    logic edge_tgl_q;
    logic [7:0] link_byte_q;
    always_ff @(posedge sample_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else begin
            shift_q <= {shift_q[6:0], mosi}; // [R14]
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end
    always_ff @(posedge sample_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_tgl_q <= 1'b0;
            edge_tgl_q <= 1'b0;
            link_byte_q <= 8'h00;
        end else if (link_rst_n) begin
            edge_tgl_q <= !edge_tgl_q; // [R9]
            if (bit_cnt_q == 3'h7) begin
                link_byte_q <= {shift_q[6:0], mosi};
                byte_tgl_q <= !byte_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Crossing back to the system clock
    // ------------------------------------------------------------
    logic [2:0] byte_sync_q;
    logic [2:0] edge_sync_q;
    logic byte_done;
    logic edge_seen;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_sync_q <= 3'h0;
            edge_sync_q <= 3'h0;
        end else if (clk_en) begin
            byte_sync_q <= {byte_sync_q[1:0], byte_tgl_q};
            edge_sync_q <= {edge_sync_q[1:0], edge_tgl_q};
        end
    end
    assign byte_done = byte_sync_q[2] ^ byte_sync_q[1];
    assign edge_seen = edge_sync_q[2] ^ edge_sync_q[1];
    // Toggle stable two cycles before use, so the byte is settled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte <= 8'h00;
        end else if (clk_en && byte_done) begin
            rx_byte <= link_byte_q;
        end
    end

    // ------------------------------------------------------------
    // Slave status flags
    // ------------------------------------------------------------
    spicfg_state_e state_q;
    logic rx_empty_q;
    logic shift_empty_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_empty_q <= 1'b1;
        end else if (clk_en) begin
            if (byte_done) begin
                rx_empty_q <= 1'b0; // [R12]
            end else if (rx_read) begin
                rx_empty_q <= 1'b1; // [R11]
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: begin
                    if (tx_load || edge_seen) begin
                        state_q <= ST_SHIFT; // [R9]
                    end
                end
                ST_SHIFT: begin
                    if (byte_done) begin
                        state_q <= ST_HOLD;
                    end else if (!slave_active) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (tx_load || edge_seen) begin
                        state_q <= ST_SHIFT;
                    end else begin
                        state_q <= ST_IDLE; // [R8]
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign shift_empty_q = state_q == ST_IDLE;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic busy;
    logic [7:0] status;
    assign busy = master_select_q ? master_busy :
        (slave_active && state_q != ST_IDLE); // [R1]
    always_comb begin
        status = 8'h00;
        status[`SPICFG_BIT_BUSY] = busy; // [R1]
        status[`SPICFG_BIT_MSTR] = master_select_q;
        status[`SPICFG_BIT_CPHA] = clock_phase_select_q;
        status[`SPICFG_BIT_CPOL] = clock_polarity_select_q;
        status[`SPICFG_BIT_SEL] = selected_flag; // [R5]
        status[`SPICFG_BIT_RAW] = ss_s_q; // [R7]
        status[`SPICFG_BIT_SHIFTER_EMPTY_FLAG] = master_select_q | shift_empty_q; // [R10]
        status[`SPICFG_BIT_RXMT] = master_select_q | rx_empty_q; // [R13]
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (clk_en && bus.rd) begin
            rdata <= reg_hit ? status : 8'h00;
        end
    end

    // Master sampling (MISO late in bit) lives in the master engine [R15]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_master_shifter_empty_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        master_select_q |-> status[`SPICFG_BIT_SHIFTER_EMPTY_FLAG]) // [R10]
        else $error("shifter empty low in master mode");
    a_master_rxmt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        master_select_q |-> status[`SPICFG_BIT_RXMT]) // [R13]
        else $error("rx empty low in master mode");
    a_rx_new_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_done |=> !rx_empty_q) // [R12]
        else $error("new byte did not clear rx empty");
    a_rx_read_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && rx_read && !byte_done |=> rx_empty_q) // [R11]
        else $error("read did not set rx empty");
    a_cfg_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && bus.wr && reg_hit |=>
        status[6:4] == $past(bus.wdata[6:4])) // [R2]
        else $error("config bits not stored");
    a_sel_filter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(ss_filt_q) |-> $past(ss_s_q) != $past(ss_filt_q)) // [R6]
        else $error("filtered select changed without cause");
    a_sel_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        status[`SPICFG_BIT_SEL] == !ss_filt_q) // [R5]
        else $error("selected flag mismatch");
    a_busy_slave: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !master_select_q && !shift_empty_q && slave_active
        |-> status[`SPICFG_BIT_BUSY]) // [R1]
        else $error("busy low during slave transfer");
    a_load_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && tx_load && state_q == ST_IDLE |=> !shift_empty_q) // [R9]
        else $error("load did not clear shifter empty");

    // ------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------
    // Raw bit is the pin seen through the two-flop synchroniser
    a_raw_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && $past(clk_en) |->
        status[`SPICFG_BIT_RAW] == $past(slave_select_n, 2)) // [R7]
        else $error("raw select bit not two cycles behind pin");
    a_busy_master: assert property (@(posedge clk_sys) disable iff (!rst_n)
        master_select_q |-> status[`SPICFG_BIT_BUSY] == master_busy) // [R1]
        else $error("busy bit does not follow master engine");
    a_rdata_miss: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && bus.rd && !reg_hit |=> rdata == 8'h00) // [R18]
        else $error("read of other address not zero");
    a_rdata_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && bus.rd && reg_hit |=>
        rdata == $past(status)) // [R18]
        else $error("read data does not match status");
    // Config bits change only on a write that hits this register
    a_cfg_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && !(bus.wr && reg_hit) |=>
        $stable(status[6:4])) // [R18]
        else $error("config bits changed without write");

    // ------------------------------------------------------------
    // Flag and link checks
    // ------------------------------------------------------------
    a_hold_leaves: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && state_q == ST_HOLD |=> state_q != ST_HOLD) // [R8]
        else $error("shifter stuck in hold");
    a_edge_wakes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && edge_seen && state_q == ST_IDLE |=>
        state_q == ST_SHIFT) // [R9]
        else $error("clock edge did not clear shifter empty");
    a_byte_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_done && state_q == ST_SHIFT |=>
        state_q == ST_HOLD) // [R8]
        else $error("finished byte did not reach hold");
    // Counter never passes the filter length
    a_filter_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        glitch_cnt_q < 8'(GLITCH_CYC)) // [R6]
        else $error("filter counter out of range");
    a_sel_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && ss_s_q == ss_filt_q |=>
        $stable(ss_filt_q) && glitch_cnt_q == 8'h00) // [R6]
        else $error("filter moved while pin was steady");
    // Byte is taken only once the toggle has settled
    a_rx_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_done |=> rx_byte == $past(link_byte_q)) // [R12]
        else $error("received byte not captured");
    a_rx_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && !byte_done |=> $stable(rx_byte)) // [R12]
        else $error("received byte changed without a transfer");
    a_busy_shifter_empty_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !master_select_q && status[`SPICFG_BIT_BUSY] |->
        !status[`SPICFG_BIT_SHIFTER_EMPTY_FLAG]) // [R1]
        else $error("busy with shifter empty in slave mode");
endmodule

//--- spicfg_master_model.sv
// External SPI master that drives the link side of the port
`timescale 1ns/1ps
module spicfg_master_model (
    // Mode
    input wire logic cpol,
    input wire logic cpha,
    // Link pins
    output logic sck_link,
    output logic slave_select_n,
    output logic mosi
);
    logic in_frame;
    logic edge_q;

    // Clock stands at its idle level outside frames
    assign sck_link = in_frame ? edge_q : cpol;

    initial begin
        in_frame = 1'b0;
        edge_q = 1'b0;
        slave_select_n = 1'b1;
        mosi = 1'b0;
    end

    // Select leads the first edge by more than 2 system clocks
    task automatic send(input logic [7:0] b);
        slave_select_n = 1'b0;
        #30;
        edge_q = cpol;
        in_frame = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            if (cpha) begin
                #6 edge_q = ~cpol;
                mosi = b[i];
                #6 edge_q = cpol;
            end else begin
                mosi = b[i];
                #6 edge_q = ~cpol;
                #6 edge_q = cpol;
            end
        end
        #6 in_frame = 1'b0;
        slave_select_n = 1'b1;
        // Released line must not keep the last bit
        mosi = ~mosi;
    endtask

    // Low pulse one system clock long, too short for the filter
    task automatic glitch();
        slave_select_n = 1'b0;
        #10 slave_select_n = 1'b1;
    endtask
endmodule

//--- spi_config_status_register_test.sv
// Self-checking bench for the SPI configuration and status register
`timescale 1ns/1ps
`include "spicfg_consts.svh"
module spi_config_status_register_test;
    import spicfg_pkg::*;
    logic clk_sys, rst_n, port_enable, master_busy, tx_load, rx_read;
    logic cpol, cpha;
    logic [1:0] select_pin_mode;
    spicfg_bus_s bus;
    logic [7:0] rdata, rx_byte, d;
    logic [7:0] tbl [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    wire sck_link, slave_select_n, mosi;
    int miscompares, check_count;

    spicfg_top #(.GLITCH_CYC(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(1'b1), .bus(bus), .rdata(rdata), .port_enable(port_enable),
        .select_pin_mode(select_pin_mode), .master_busy(master_busy),
        .tx_load(tx_load), .rx_read(rx_read), .sck_link(sck_link),
        .slave_select_n(slave_select_n), .mosi(mosi), .rx_byte(rx_byte));
    spicfg_master_model i_master (.cpol(cpol), .cpha(cpha),
        .sck_link(sck_link), .slave_select_n(slave_select_n), .mosi(mosi));

    // ----------------------------------------
    // Access and checking tasks
    // ----------------------------------------
    task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        bus.addr = a;
        bus.wdata = v;
        bus.wr = 1'b1;
        @(negedge clk_sys);
        bus.wr = 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge clk_sys);
        bus.rd = 1'b0;
        v = rdata;
    endtask

    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp1(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cuts a hang short
    initial begin
        #50000;
        miscompares++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {port_enable, master_busy, tx_load, rx_read, cpol, cpha} = '0;
        select_pin_mode = `SPICFG_MODE_4WIRE;
        bus = '0;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        bus_read(`SPICFG_ADDR, d);
        cmp8("reset status", `SPICFG_RESET, d);
        bus_write(`SPICFG_ADDR, 8'hff);
        bus_read(`SPICFG_ADDR, d);
        cmp8("master status", 8'h77, d);
        master_busy = 1'b1;
        bus_read(`SPICFG_ADDR, d);
        cmp1("busy as master", 1'b1, d[7]);
        master_busy = 1'b0;
        bus_write(8'ha2, 8'h00);
        bus_read(8'ha2, d);
        cmp8("unmapped read", 8'h00, d);
        bus_read(`SPICFG_ADDR, d);
        cmp8("after stray write", 8'h77, d);
        for (int m = 0; m < 4; m++) begin
            port_enable = 1'b0;
            {cpha, cpol} = m[1:0];
            bus_write(`SPICFG_ADDR, {2'b00, cpha, cpol, 4'h0});
            port_enable = 1'b1;
            tx_load = 1'b1;
            @(negedge clk_sys);
            tx_load = 1'b0;
            bus_read(`SPICFG_ADDR, d);
            cmp1("shifter after load", 1'b0, d[1]);
            fork
                i_master.send(tbl[m]);
                begin
                    repeat (7) @(negedge clk_sys);
                    bus_read(`SPICFG_ADDR, d);
                    cmp1("busy in slave", 1'b1, d[7]);
                    cmp1("selected", 1'b1, d[3]);
                    cmp1("raw pin", 1'b0, d[2]);
                end
            join
            for (int i = 0; i < 20 && rx_byte !== tbl[m]; i++)
                @(negedge clk_sys);
            cmp8("rx byte", tbl[m], rx_byte);
            bus_read(`SPICFG_ADDR, d);
            cmp8("status after byte", 8'h02, d & 8'h83);
            rx_read = 1'b1;
            @(negedge clk_sys);
            rx_read = 1'b0;
            bus_read(`SPICFG_ADDR, d);
            cmp1("rx empty after read", 1'b1, d[0]);
        end
        select_pin_mode = `SPICFG_MODE_3WIRE;
        port_enable = 1'b0;
        @(negedge clk_sys);
        port_enable = 1'b1;
        i_master.send(8'h5a);
        for (int i = 0; i < 20 && rx_byte !== 8'h5a; i++)
            @(negedge clk_sys);
        cmp8("rx byte 3-wire", 8'h5a, rx_byte);
        select_pin_mode = `SPICFG_MODE_4WIRE;
        @(negedge clk_sys);
        i_master.glitch();
        repeat (4) @(negedge clk_sys);
        bus_read(`SPICFG_ADDR, d);
        cmp1("selected after glitch", 1'b0, d[3]);
        finish_test();
    end
endmodule
